// ===== rtl/capture_defs.svh
// register offsets, field positions and reset values of the capture unit
`ifndef CAPTURE_DEFS_SVH
`define CAPTURE_DEFS_SVH

`define CAP_OFF_CONTROL   12'h000
`define CAP_OFF_SOURCE    12'h004
`define CAP_OFF_FLAG      12'h008
`define CAP_OFF_LOW       12'h00C
`define CAP_OFF_HIGH      12'h010
`define CAP_OFF_PORT      12'h014

`define CAP_CTRL_EN_BIT   7
`define CAP_MODE_MSB      3
`define CAP_SRC_MSB       2
`define CAP_FLAG_BIT      0
`define CAP_PORT_DIR_BIT  0
`define CAP_PORT_VAL_BIT  1

`define CAP_CTRL_RST      8'h00
`define CAP_SRC_RST       3'h0
`define CAP_PORT_RST      2'h1
`define CAP_PRE4_LAST     4'h3
`define CAP_PRE16_LAST    4'hF

`endif

// ===== rtl/capture_pkg.sv
// types shared by the capture unit
package capture_pkg;
  typedef enum logic [3:0] {
    MODE_OFF     = 4'h0,
    MODE_ANY     = 4'h3,
    MODE_FALL    = 4'h4,
    MODE_RISE    = 4'h5,
    MODE_RISE4   = 4'h6,
    MODE_RISE16  = 4'h7
  } cap_mode_e;
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_e;
endpackage

// ===== rtl/timer_capture_unit.sv
// input capture unit with an axi4-lite register slave
//
// How it works
// RQ1: each qualifying event copies the 16-bit timer count into the byte pair.
// RQ2: four-bit mode picks fall, rise, every 4th, every 16th rise, or any edge.
// RQ3: every capture sets the capture event flag.
// RQ4: software clears the flag; reading the capture never clears it.
// RQ5: a new capture overwrites an unread value, no queueing.
// RQ6: each byte register updates on the event, so split reads can mix.
// RQ7: software disables the unit or reads twice for a coherent value.
// RQ8: a three-bit source field picks the signal feeding the edge detector.
// RQ9: software keeps the pin an input while capture is in use.
// RQ10: with the pin driven as output, the written value can trigger capture.
// RQ11: the timer runs in timer or synchronized counter mode.
// RQ12: the timer is clocked at instruction rate or externally, not raw osc.
// RQ13: the source is synchronised first; prescaler restarts on a mode change.
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "capture_defs.svh"
module timer_capture_unit (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // capture sources and timer count
  input  wire logic        capture_input_pin_i,
  input  wire logic [7:0]  capture_alt_src_i,
  input  wire logic [15:0] timer_count_i,
  // capture pin drive
  output logic             capture_pin_o,
  output logic             capture_pin_oe_o,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // register state
  logic [7:0]  capture_control_reg_q;
  logic [2:0]  capture_source_reg_q;
  logic [1:0]  port_reg_q;
  logic        capture_event_flag_q;
  logic [7:0]  capture_low_byte_q;
  logic [7:0]  capture_high_byte_q;
  // bus state
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic        aw_held_q;
  logic        w_held_q;
  logic        wstrb0_q;
  // detector state
  logic [7:0]  sync1_q;
  logic [7:0]  sync2_q;
  logic        src_prev_q;
  logic [3:0]  pre_cnt_q;
  logic [3:0]  mode_prev_q;

  // decode of an address to a register select
  function automatic logic is_reg(input logic [11:0] a,
                                  input logic [11:0] off);
    is_reg = (a == off);
  endfunction

  // source selection and edge detection on the synchronised sources
  wire logic       cap_en       = capture_control_reg_q[`CAP_CTRL_EN_BIT];
  wire logic [3:0] mode         = capture_control_reg_q[`CAP_MODE_MSB:0];
  wire logic       src_now      = sync2_q[capture_source_reg_q]; // RQ8
  wire logic       rise         = src_now & ~src_prev_q;
  wire logic       fall         = ~src_now & src_prev_q;
  wire logic       mode_chg     = (mode != mode_prev_q); // RQ13
  wire logic       pre4_hit     = rise && (pre_cnt_q == `CAP_PRE4_LAST);
  wire logic       pre16_hit    = rise && (pre_cnt_q == `CAP_PRE16_LAST);
  wire logic       pre_wrap     = (mode == capture_pkg::MODE_RISE4) ?
                                  pre4_hit : pre16_hit;
  // RQ2
  wire logic       ev_any       = (mode == capture_pkg::MODE_ANY) &
                                  (rise | fall);
  wire logic       ev_fall      = (mode == capture_pkg::MODE_FALL) & fall;
  wire logic       ev_rise      = (mode == capture_pkg::MODE_RISE) & rise;
  wire logic       ev_r4        = (mode == capture_pkg::MODE_RISE4) &
                                  pre4_hit;
  wire logic       ev_r16       = (mode == capture_pkg::MODE_RISE16) &
                                  pre16_hit;
  wire logic       cap_event    = cap_en & ~mode_chg &
                                  (ev_any | ev_fall | ev_rise | ev_r4 | ev_r16);
  // pin drive mirrors the port register; the pin is sync source 0
  wire logic       pin_level    = port_reg_q[`CAP_PORT_DIR_BIT] ?
                                  capture_input_pin_i :
                                  port_reg_q[`CAP_PORT_VAL_BIT]; // RQ10
  wire logic [7:0] src_vec      = {capture_alt_src_i[7:1], pin_level};

  // bus write decode; a cleared lane-0 strobe leaves every register alone
  wire logic       do_write     = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire logic       wr_ctrl      = do_write & wstrb0_q &
                                  is_reg(awaddr_q, `CAP_OFF_CONTROL);
  wire logic       wr_src       = do_write & wstrb0_q &
                                  is_reg(awaddr_q, `CAP_OFF_SOURCE);
  wire logic       wr_flag      = do_write & wstrb0_q &
                                  is_reg(awaddr_q, `CAP_OFF_FLAG);
  wire logic       wr_port      = do_write & wstrb0_q &
                                  is_reg(awaddr_q, `CAP_OFF_PORT);
  wire logic       wr_hit       = is_reg(awaddr_q, `CAP_OFF_CONTROL) |
                                  is_reg(awaddr_q, `CAP_OFF_SOURCE) |
                                  is_reg(awaddr_q, `CAP_OFF_FLAG) |
                                  is_reg(awaddr_q, `CAP_OFF_LOW) |
                                  is_reg(awaddr_q, `CAP_OFF_HIGH) |
                                  is_reg(awaddr_q, `CAP_OFF_PORT);

  // bus read decode; reads have no side effect on the flag
  wire logic       rd_take      = s_axi_arvalid & s_axi_arready; // RQ4
  wire logic [31:0] rd_mux      =
    is_reg(s_axi_araddr, `CAP_OFF_CONTROL) ? {24'h0, capture_control_reg_q} :
    is_reg(s_axi_araddr, `CAP_OFF_SOURCE)  ? {29'h0, capture_source_reg_q} :
    is_reg(s_axi_araddr, `CAP_OFF_FLAG)    ? {31'h0, capture_event_flag_q} :
    is_reg(s_axi_araddr, `CAP_OFF_LOW)     ? {24'h0, capture_low_byte_q} :
    is_reg(s_axi_araddr, `CAP_OFF_HIGH)    ? {24'h0, capture_high_byte_q} :
    is_reg(s_axi_araddr, `CAP_OFF_PORT)    ? {30'h0, port_reg_q} : 32'h0;
  wire logic       rd_hit       = is_reg(s_axi_araddr, `CAP_OFF_CONTROL) |
                                  is_reg(s_axi_araddr, `CAP_OFF_SOURCE) |
                                  is_reg(s_axi_araddr, `CAP_OFF_FLAG) |
                                  is_reg(s_axi_araddr, `CAP_OFF_LOW) |
                                  is_reg(s_axi_araddr, `CAP_OFF_HIGH) |
                                  is_reg(s_axi_araddr, `CAP_OFF_PORT);

  // two-flop synchroniser on every source
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= src_vec; // RQ13
      sync2_q <= sync1_q;
    end
  end

  // edge history, prescaler and mode history
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_prev_q  <= 1'b0;
      pre_cnt_q   <= 4'h0;
      mode_prev_q <= 4'h0;
    end else begin
      src_prev_q  <= src_now;
      mode_prev_q <= mode;
      if (mode_chg || !cap_en) begin
        pre_cnt_q <= 4'h0; // RQ13
      end else if (rise) begin
        pre_cnt_q <= pre_wrap ? 4'h0 : pre_cnt_q + 4'h1;
      end
    end
  end

  // capture registers: both bytes load together, overwriting old data
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      capture_low_byte_q  <= 8'h00;
      capture_high_byte_q <= 8'h00;
    end else if (cap_event) begin
      capture_low_byte_q  <= timer_count_i[7:0];  // RQ1 RQ5 RQ6
      capture_high_byte_q <= timer_count_i[15:8]; // RQ1
    end
  end

  // event flag: set wins over a software clear in the same cycle
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      capture_event_flag_q <= 1'b0;
    end else if (cap_event) begin
      capture_event_flag_q <= 1'b1; // RQ3
    end else if (wr_flag) begin
      capture_event_flag_q <= wdata_q[`CAP_FLAG_BIT]; // RQ4
    end
  end

  // software registers
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      capture_control_reg_q <= `CAP_CTRL_RST;
      capture_source_reg_q  <= `CAP_SRC_RST;
      port_reg_q            <= `CAP_PORT_RST;
    end else begin
      if (wr_ctrl) capture_control_reg_q <= wdata_q[7:0];
      if (wr_src)  capture_source_reg_q  <= wdata_q[`CAP_SRC_MSB:0]; // RQ8
      if (wr_port) port_reg_q            <= wdata_q[1:0];
    end
  end

  // pin drive outputs
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      capture_pin_o    <= 1'b0;
      capture_pin_oe_o <= 1'b0;
    end else begin
      capture_pin_o    <= port_reg_q[`CAP_PORT_VAL_BIT];
      capture_pin_oe_o <= ~port_reg_q[`CAP_PORT_DIR_BIT];
    end
  end

  // axi write channels: address and data latched in either order
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb0_q      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= capture_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= {s_axi_awaddr[11:2], 2'b00};
        aw_held_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb0_q     <= s_axi_wstrb[0];
        w_held_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? capture_pkg::RESP_OKAY :
                                 capture_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi read channels
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= capture_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? capture_pkg::RESP_OKAY :
                                capture_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // assertions
  cap_load_a: assert property ( // RQ1
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_event |=> {capture_high_byte_q, capture_low_byte_q}
                  == $past(timer_count_i))
    else $error("capture pair did not load the timer count");
  cap_flag_set_a: assert property ( // RQ3
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_event |=> capture_event_flag_q)
    else $error("flag not set after capture");
  flag_sticky_a: assert property ( // RQ4
    @(posedge core_clk_i) disable iff (sys_rst_i)
    capture_event_flag_q && !wr_flag |=> capture_event_flag_q)
    else $error("flag cleared without a software write");
  fall_mode_a: assert property ( // RQ2
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_event && mode == capture_pkg::MODE_FALL |-> fall)
    else $error("falling mode captured on a non-falling edge");
  rise16_cnt_a: assert property ( // RQ2
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_event && mode == capture_pkg::MODE_RISE16 |-> pre_cnt_q == 4'hF)
    else $error("every-16th capture at wrong prescale count");
  hold_no_event_a: assert property ( // RQ6
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !cap_event |=> $stable(capture_low_byte_q))
    else $error("capture low byte moved without an event");
  pre_restart_a: assert property ( // RQ13
    @(posedge core_clk_i) disable iff (sys_rst_i)
    mode_chg |=> pre_cnt_q == 4'h0)
    else $error("prescaler did not restart on mode change");
  sync_delay_a: assert property ( // RQ13
    @(posedge core_clk_i) disable iff (sys_rst_i)
    ##2 sync2_q == $past(src_vec, 2))
    else $error("source synchroniser latency wrong");
  src_sel_a: assert property ( // RQ8
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_event && mode == capture_pkg::MODE_RISE |->
      sync2_q[capture_source_reg_q] &&
      !$past(sync2_q[capture_source_reg_q]))
    else $error("rise capture not on an edge of the selected source");
  drive_cap_a: assert property ( // RQ10
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !port_reg_q[`CAP_PORT_DIR_BIT] |->
      ##2 sync2_q[0] == $past(port_reg_q[`CAP_PORT_VAL_BIT], 2))
    else $error("driven pin value not seen by detector");
  overwrite_a: assert property ( // RQ5
    @(posedge core_clk_i) disable iff (sys_rst_i)
    cap_event && capture_event_flag_q |=>
      {capture_high_byte_q, capture_low_byte_q} == $past(timer_count_i))
    else $error("pending capture was not overwritten");
  cap_any_c: cover property (@(posedge core_clk_i)
    cap_event && mode == capture_pkg::MODE_ANY);
  cap_r4_c: cover property (@(posedge core_clk_i) ev_r4);
  set_clr_c: cover property (@(posedge core_clk_i) cap_event && wr_flag);
endmodule

// ===== test/capture_far_side.sv
// model of the capture input wiring and the companion sixteen-bit timer
`timescale 1ns/1ps
module capture_far_side (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // commanded source levels and timer start value
  input  wire logic [15:0] seed_i,
  input  wire logic [7:0]  level_i,
  // pin drive from the unit
  input  wire logic        pin_drive_i,
  input  wire logic        pin_oe_i,
  // resolved sources and timer
  output logic             pin_o,
  output logic [7:0]       alt_o,
  output logic [15:0]      count_o,
  output logic             tick_o
);
  logic [5:0] div_q;

  // timer clocked by a slow external clock, synchronised counting
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_q   <= 6'h00;
      count_o <= seed_i;
    end else begin
      div_q <= div_q + 6'h01;
      if (div_q == 6'h3F) count_o <= count_o + 16'h0001;
    end
  end

  // tick marks a fresh timer value that holds for 63 more cycles
  assign tick_o = (div_q == 6'h00);
  // pin kept an input unless the unit drives it
  assign pin_o  = pin_oe_i ? pin_drive_i : level_i[0];
  // bit 0 is unused by the unit, so it carries a changing level
  assign alt_o  = {level_i[7:1], ~level_i[0]};
endmodule

// ===== test/timer_capture_unit_tb.sv
// self-checking bench of the capture unit
`timescale 1ns/1ps
`include "capture_defs.svh"
module timer_capture_unit_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  lvl = 8'h00;
  logic [15:0] seed_v = 16'h0000;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        pin_w, tick, pin_o, pin_oe, awready, wready, bvalid;
  logic        arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  alt;
  logic [15:0] cnt, cap_v;
  logic [33:0] wq[$];
  logic [33:0] rq[$];
  capture_pkg::cap_mode_e md;
  int          mismatches = 0;
  int          total_checks = 0;
  int          seed = 25;
  int          n;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  capture_far_side capture_far_side_i (.core_clk_i(clk), .sys_rst_i(rst),
    .seed_i(seed_v), .level_i(lvl), .pin_drive_i(pin_o), .pin_oe_i(pin_oe),
    .pin_o(pin_w), .alt_o(alt), .count_o(cnt), .tick_o(tick));

  timer_capture_unit timer_capture_unit_i (.core_clk_i(clk), .sys_rst_i(rst),
    .capture_input_pin_i(pin_w), .capture_alt_src_i(alt),
    .timer_count_i(cnt), .capture_pin_o(pin_o), .capture_pin_oe_o(pin_oe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic chk(input logic [33:0] s, input logic [33:0] e,
                     input string m);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // register write, response noted for the monitor
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er = capture_pkg::RESP_OKAY);
    wq.push_back({32'h0, er});
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // register read, expected data noted for the monitor
  task automatic axr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er = capture_pkg::RESP_OKAY);
    rq.push_back({er, d});
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // wait for a fresh timer value
  task automatic wtick();
    do @(posedge clk);
    while (tick !== 1'b1);
  endtask

  // move one source level; note the count when a capture is due
  task automatic stim(input int i, input logic v, input logic c);
    wtick();
    lvl[i] <= v;
    if (c) cap_v = cnt;
    repeat (8) @(posedge clk);
  endtask

  // flag and both capture bytes
  task automatic chkcap();
    axr(`CAP_OFF_FLAG, 32'h1);
    axr(`CAP_OFF_LOW, {24'h0, cap_v[7:0]});
    axr(`CAP_OFF_HIGH, {24'h0, cap_v[15:8]});
  endtask

  // monitor takes the oldest note as each answer appears
  always @(posedge clk) begin
    if (bvalid === 1'b1 && bready)
      chk({32'h0, bresp}, wq.pop_front(), "bresp");
    if (rvalid === 1'b1 && rready)
      chk({rresp, rdata}, rq.pop_front(), "rdata");
  end

  // watchdog well beyond the expected run length
  initial begin
    #2000000;
    mismatches++;
    $display("unexpected at %0t: timeout", $time);
    final_report();
  end

  initial begin
    seed_v = 16'($random(seed));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    axr(`CAP_OFF_CONTROL, 32'h0);
    axr(`CAP_OFF_SOURCE, 32'h0);
    axr(`CAP_OFF_FLAG, 32'h0);
    axr(`CAP_OFF_PORT, 32'h1);
    axr(12'h020, 32'h0, capture_pkg::RESP_SLVERR);
    axw(12'h020, 32'h1, capture_pkg::RESP_SLVERR);
    $display("test reset and decode done");
    // fall, rise and any-edge modes, in any-edge the first capture left unread before the second
    for (int k = 0; k < 3; k++) begin
      md = (k == 0) ? capture_pkg::MODE_FALL :
           (k == 1) ? capture_pkg::MODE_RISE : capture_pkg::MODE_ANY;
      axw(`CAP_OFF_CONTROL, {24'h0, 4'h8, md});
      axw(`CAP_OFF_FLAG, 32'h0);
      stim(0, 1'b1, md != capture_pkg::MODE_FALL);
      axr(`CAP_OFF_FLAG, {31'h0, md != capture_pkg::MODE_FALL});
      stim(0, 1'b0, md != capture_pkg::MODE_RISE);
      chkcap();
      axr(`CAP_OFF_FLAG, 32'h1);
    end
    $display("test edge modes done");
    // prescaled modes, counter restarted by a mode change
    for (int k = 0; k < 2; k++) begin
      md = k ? capture_pkg::MODE_RISE16 : capture_pkg::MODE_RISE4;
      n  = k ? 16 : 4;
      axw(`CAP_OFF_CONTROL, {24'h0, 4'h8, md});
      axw(`CAP_OFF_FLAG, 32'h0);
      repeat (2) begin
        stim(0, 1'b1, 1'b0);
        stim(0, 1'b0, 1'b0);
      end
      axw(`CAP_OFF_CONTROL, {24'h0, 4'h8, capture_pkg::MODE_RISE});
      axw(`CAP_OFF_CONTROL, {24'h0, 4'h8, md});
      axw(`CAP_OFF_FLAG, 32'h0);
      for (int i = 1; i <= n; i++) begin
        stim(0, 1'b1, i == n);
        if (i == n - 1) axr(`CAP_OFF_FLAG, 32'h0);
        stim(0, 1'b0, 1'b0);
      end
      chkcap();
    end
    $display("test prescaled modes done");
    // source select: pin ignored, source 3 captured
    axw(`CAP_OFF_SOURCE, 32'h3);
    axw(`CAP_OFF_CONTROL, {24'h0, 4'h8, capture_pkg::MODE_RISE});
    axw(`CAP_OFF_FLAG, 32'h0);
    stim(0, 1'b1, 1'b0);
    stim(0, 1'b0, 1'b0);
    axr(`CAP_OFF_FLAG, 32'h0);
    stim(3, 1'b1, 1'b1);
    chkcap();
    stim(3, 1'b0, 1'b0);
    $display("test source select done");
    // pin driven as output: written value triggers a capture
    axw(`CAP_OFF_SOURCE, 32'h0);
    axw(`CAP_OFF_FLAG, 32'h0);
    wtick();
    axw(`CAP_OFF_PORT, 32'h2);
    cap_v = cnt;
    repeat (8) @(posedge clk);
    chk({32'h0, pin_oe, pin_o}, 34'h3, "pin drive");
    chkcap();
    axr(`CAP_OFF_LOW, {24'h0, cap_v[7:0]});
    axr(`CAP_OFF_HIGH, {24'h0, cap_v[15:8]});
    axw(`CAP_OFF_PORT, 32'h1);
    axr(`CAP_OFF_PORT, 32'h1);
    $display("test pin output done");
    final_report();
  end
endmodule
